// >>> core/dsw_pkg.sv
package dsw_pkg;

  // ==========================================================
  // Clock and serial port limits
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned CLK_KHZ = CLK_MHZ * 1000;
  localparam int unsigned FRAME_BITS = 16;
  localparam int unsigned SCLK_MAX_KHZ = 8000;
  localparam int unsigned SCLK_MARGIN = 4;

  // ==========================================================
  // Times in their own units and derived cycle counts
  localparam int unsigned WDOG_TIME_US = 32000;
  localparam int unsigned WDOG_CYC_DEF = WDOG_TIME_US * CLK_MHZ;
  localparam int unsigned BULB_INRUSH_US = 1000;
  localparam int unsigned BULB_CYC_DEF = BULB_INRUSH_US * CLK_MHZ;
  localparam int unsigned MOTOR_INRUSH_US = 5000;
  localparam int unsigned MOTOR_CYC_DEF = MOTOR_INRUSH_US * CLK_MHZ;
  localparam int unsigned RETRY_TIME_US = 10000;
  localparam int unsigned RETRY_CYC_DEF = RETRY_TIME_US * CLK_MHZ;
  localparam int unsigned SETTLE_TIME_NS = 20000;
  localparam int unsigned SETTLE_CYC = (SETTLE_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned PWM_PRESCALE = 16;

  // ==========================================================
  // Command word layout: address on top, data below
  localparam int unsigned ADDR_LSB = 13;
  localparam logic [2:0] ADDR_CH0 = 3'h1;
  localparam logic [2:0] ADDR_CH1 = 3'h2;
  localparam logic [2:0] ADDR_GLOBAL = 3'h3;
  localparam int unsigned DUTY_LSB = 0;
  localparam int unsigned SRC_LSB = 8;
  localparam int unsigned RETRY_BIT = 10;
  localparam int unsigned PROF_BIT = 11;
  localparam int unsigned PROF_USE_BIT = 12;
  localparam int unsigned SENSE_SEL_LSB = 0;
  localparam int unsigned RATIO_BIT = 2;
  localparam int unsigned CLEAR_BIT = 3;
  localparam logic [12:0] CH_CFG_RST = 13'h0000;
  localparam logic [12:0] GLB_CFG_RST = 13'h0000;

  // ==========================================================
  // Synchroniser vector positions
  localparam int unsigned IX_CS = 18;
  localparam int unsigned IX_RSTPIN = 17;
  localparam int unsigned IX_PWMCLK = 16;
  localparam int unsigned IX_DIN = 14;
  localparam int unsigned IX_PROF = 12;
  localparam int unsigned IX_OCHI = 10;
  localparam int unsigned IX_OCLO = 8;
  localparam int unsigned IX_SC = 6;
  localparam int unsigned IX_OT = 4;
  localparam int unsigned IX_OLOFF = 2;
  localparam int unsigned IX_OLON = 0;
  localparam logic [18:0] SYNC_RST = 19'h60000;

  typedef enum logic [1:0] {
    SRC_DIRECT = 2'h0,
    SRC_INTERNAL = 2'h1,
    SRC_EXTERNAL = 2'h2
  } src_e;

  typedef enum logic [1:0] {
    SENSE_CUR0 = 2'h0,
    SENSE_CUR1 = 2'h1,
    SENSE_TEMP = 2'h2
  } sense_e;

  typedef enum logic [2:0] {
    MODE_NORMAL = 3'b001,
    MODE_FAILSAFE = 3'b010,
    MODE_SLEEP = 3'b100
  } mode_e;

endpackage

// >>> core/spi_link.sv
module spi_link import dsw_pkg::*; (
  input wire logic i_sclk,
  input wire logic i_chip_select_n,
  input wire logic i_si,
  input wire logic [15:0] i_tx_word,
  output logic o_so,
  output logic [15:0] o_rx_word,
  output logic o_frame_ok
);

  logic [4:0] cnt_ff;
  logic [15:0] rx_sh_ff;
  logic [15:0] rx_word_ff;
  logic so_ff;
  logic ok_ff;
  logic over_ff;

  // ==========================================================
  // Bit counter, cleared by the frame's own select line
  // The link clock stops between frames, so no edge may be needed to end one
  always_ff @(posedge i_sclk or posedge i_chip_select_n) begin
    if (i_chip_select_n) begin
      cnt_ff <= 5'h00;
    end else if (cnt_ff != 5'h11) begin
      cnt_ff <= cnt_ff + 5'h01;
    end
  end

  // ==========================================================
  // Reply shifts on rising edges, command is sampled on falling edges
  always_ff @(posedge i_sclk) begin
    if (cnt_ff < 5'h10) begin
      so_ff <= i_tx_word[4'hf - cnt_ff[3:0]];
    end
    over_ff <= (cnt_ff >= 5'h10);
  end

  always_ff @(negedge i_sclk) begin
    rx_sh_ff <= {rx_sh_ff[14:0], i_si};
    ok_ff <= (cnt_ff == 5'h10);
    if (cnt_ff == 5'h10) begin
      rx_word_ff <= {rx_sh_ff[14:0], i_si};
    end
  end

  assign o_so = so_ff;
  assign o_rx_word = rx_word_ff;
  assign o_frame_ok = ok_ff & ~over_ff;

endmodule  // spi_link

// >>> core/dual_switch_control_pins.sv
module dual_switch_control_pins import dsw_pkg::*; #(
  parameter int unsigned WDOG_CYC = WDOG_CYC_DEF,
  parameter int unsigned BULB_CYC = BULB_CYC_DEF,
  parameter int unsigned MOTOR_CYC = MOTOR_CYC_DEF,
  parameter int unsigned RETRY_CYC = RETRY_CYC_DEF,
  parameter bit HAS_SPI_PROFILE = 1'b1
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_sclk,
  input wire logic i_chip_select_n,
  input wire logic i_si,
  input wire logic i_reset_n,
  input wire logic i_direct_input_0,
  input wire logic i_direct_input_1,
  input wire logic i_profile_select_0,
  input wire logic i_profile_select_1,
  input wire logic i_pwm_clock,
  input wire logic [1:0] i_overcurrent_high,
  input wire logic [1:0] i_overcurrent_low,
  input wire logic [1:0] i_short,
  input wire logic [1:0] i_overtemp,
  input wire logic [1:0] i_openload_off,
  input wire logic [1:0] i_openload_on,
  output logic o_so,
  output logic o_switch_out_0,
  output logic o_switch_out_1,
  output logic o_failsafe_out_n,
  output logic o_failsafe_out_oe,
  output logic o_fault_flag_n,
  output logic o_fault_flag_oe,
  output logic o_sync_n,
  output logic o_sync_oe,
  output logic [1:0] o_sense_select,
  output logic o_sense_ratio,
  output logic [1:0] o_oc_limit_high,
  output logic o_sleep
);

  // ==========================================================
  // Elaboration checks
  // The chip select edge is sampled, so the core clock must outrun the bit clock
  if (CLK_KHZ < SCLK_MARGIN * SCLK_MAX_KHZ) begin : g_bad_clk
    $error("core clock too slow for the serial clock");
  end
  if (WDOG_CYC == 0 || BULB_CYC == 0 || MOTOR_CYC == 0 || RETRY_CYC == 0) begin : g_bad_cyc
    $error("cycle counts must be at least one");
  end

  // ==========================================================
  // Link side
  logic [15:0] tx_word_ff;
  logic [15:0] rx_word;
  logic frame_ok;

  spi_link u_link (
    .i_sclk(i_sclk),
    .i_chip_select_n(i_chip_select_n),
    .i_si(i_si),
    .i_tx_word(tx_word_ff),
    .o_so(o_so),
    .o_rx_word(rx_word),
    .o_frame_ok(frame_ok)
  );

  // ==========================================================
  // Pin synchronisers
  logic [18:0] pins;
  logic [18:0] sync1_ff;
  logic [18:0] sync2_ff;
  logic cs_prev_ff;
  logic pwmclk_prev_ff;

  assign pins = {i_chip_select_n, i_reset_n, i_pwm_clock,
                 i_direct_input_1, i_direct_input_0,
                 i_profile_select_1, i_profile_select_0,
                 i_overcurrent_high, i_overcurrent_low, i_short,
                 i_overtemp, i_openload_off, i_openload_on};

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      sync1_ff <= SYNC_RST;
      sync2_ff <= SYNC_RST;
      cs_prev_ff <= 1'b1;
      pwmclk_prev_ff <= 1'b0;
    end else begin
      sync1_ff <= pins;
      sync2_ff <= sync1_ff;
      cs_prev_ff <= sync2_ff[IX_CS];
      pwmclk_prev_ff <= sync2_ff[IX_PWMCLK];
    end
  end

  logic pin_rst_n;
  logic [1:0] din;
  logic [1:0] prof_pin;
  logic cs_rise;
  logic cs_idle;
  logic frame_take;
  logic [2:0] cmd_addr;
  logic [12:0] cmd_data;
  logic cfg_rst;

  assign pin_rst_n = sync2_ff[IX_RSTPIN];
  assign din = sync2_ff[IX_DIN +: 2];
  assign prof_pin = sync2_ff[IX_PROF +: 2];
  // Link flops are idle once the select line has risen, so they can be read
  assign cs_rise = sync2_ff[IX_CS] & ~cs_prev_ff;
  assign cs_idle = sync2_ff[IX_CS] & cs_prev_ff;
  assign frame_take = cs_rise & frame_ok;
  assign cmd_addr = rx_word[15:ADDR_LSB];
  assign cmd_data = rx_word[12:0];
  assign cfg_rst = i_reset | ~pin_rst_n;

  // ==========================================================
  // Configuration written by the host
  logic [12:0] ch_cfg_ff [2];
  logic [12:0] glb_cfg_ff;
  logic fault_clear;

  always_ff @(posedge i_clk) begin
    if (cfg_rst) begin
      ch_cfg_ff[0] <= CH_CFG_RST;
      ch_cfg_ff[1] <= CH_CFG_RST;
    end else if (frame_take) begin
      if (cmd_addr == ADDR_CH0) begin
        ch_cfg_ff[0] <= cmd_data;
      end
      if (cmd_addr == ADDR_CH1) begin
        ch_cfg_ff[1] <= cmd_data;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (cfg_rst) begin
      glb_cfg_ff <= GLB_CFG_RST;
    end else if (frame_take && cmd_addr == ADDR_GLOBAL) begin
      glb_cfg_ff <= cmd_data & ~(13'h0001 << CLEAR_BIT);
    end
  end

  assign fault_clear = frame_take && cmd_addr == ADDR_GLOBAL && cmd_data[CLEAR_BIT];

  // ==========================================================
  // Operating mode and communication watchdog
  mode_e mode_ff;
  mode_e nxt_mode;
  logic [31:0] wdog_ff;
  logic wdog_expired;

  assign wdog_expired = (wdog_ff >= WDOG_CYC - 1);

  always_comb begin
    nxt_mode = mode_ff;
    case (mode_ff)
      MODE_NORMAL: begin
        if (!pin_rst_n && din == 2'h0) begin
          nxt_mode = MODE_SLEEP;
        end else if (wdog_expired) begin
          nxt_mode = MODE_FAILSAFE;
        end
      end
      MODE_FAILSAFE: begin
        if (!pin_rst_n && din == 2'h0) begin
          nxt_mode = MODE_SLEEP;
        end else if (frame_take) begin
          nxt_mode = MODE_NORMAL;
        end
      end
      MODE_SLEEP: begin
        if (pin_rst_n || din != 2'h0) begin
          nxt_mode = MODE_NORMAL;
        end
      end
      default: nxt_mode = MODE_NORMAL;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      mode_ff <= MODE_NORMAL;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  // Any good frame counts as host traffic; sleep restarts the window
  always_ff @(posedge i_clk) begin
    if (i_reset || frame_take || mode_ff != MODE_NORMAL) begin
      wdog_ff <= 32'h0;
    end else if (!wdog_expired) begin
      wdog_ff <= wdog_ff + 32'h1;
    end
  end

  // ==========================================================
  // PWM time bases
  logic [3:0] presc_ff;
  logic [7:0] pwm_int_ff;
  logic [7:0] pwm_ext_ff;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      presc_ff <= 4'h0;
      pwm_int_ff <= 8'h00;
    end else begin
      presc_ff <= (presc_ff == 4'(PWM_PRESCALE - 1)) ? 4'h0 : presc_ff + 4'h1;
      if (presc_ff == 4'(PWM_PRESCALE - 1)) begin
        pwm_int_ff <= pwm_int_ff + 8'h01;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      pwm_ext_ff <= 8'h00;
    end else if (sync2_ff[IX_PWMCLK] && !pwmclk_prev_ff) begin
      pwm_ext_ff <= pwm_ext_ff + 8'h01;
    end
  end

  // ==========================================================
  // Per channel control and protection
  logic [1:0] out_ff;
  logic [1:0] oc_ff;
  logic [1:0] sc_ff;
  logic [1:0] ot_ff;
  logic [1:0] olf_ff;
  logic [1:0] oln_ff;
  logic [1:0] inrush;
  logic failsafe;
  logic sleeping;

  assign failsafe = (mode_ff == MODE_FAILSAFE);
  assign sleeping = (mode_ff == MODE_SLEEP);

  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic [31:0] on_cnt_ff;
    logic [31:0] retry_ff;
    logic motor;
    logic [31:0] window;
    logic [7:0] duty;
    src_e src;
    logic req;
    logic trip_oc;
    logic latched;
    logic retry_done;
    logic clr;

    // Later versions may override the strap; otherwise the pin decides
    assign motor = (HAS_SPI_PROFILE && ch_cfg_ff[c][PROF_USE_BIT]) ?
                   ch_cfg_ff[c][PROF_BIT] : prof_pin[c];
    assign window = motor ? MOTOR_CYC : BULB_CYC;
    assign duty = ch_cfg_ff[c][DUTY_LSB +: 8];
    // Fail-safe keeps direct inputs in charge so the loads stay controllable
    assign src = failsafe ? SRC_DIRECT : src_e'(ch_cfg_ff[c][SRC_LSB +: 2]);

    always_comb begin
      case (src)
        SRC_DIRECT: req = din[c];
        SRC_INTERNAL: req = (pwm_int_ff < duty);
        SRC_EXTERNAL: req = (pwm_ext_ff < duty);
        default: req = 1'b0;
      endcase
    end

    assign inrush[c] = (on_cnt_ff < window);
    assign trip_oc = out_ff[c] &
                     (inrush[c] ? sync2_ff[IX_OCHI + c] : sync2_ff[IX_OCLO + c]);
    assign latched = oc_ff[c] | sc_ff[c] | ot_ff[c];
    assign retry_done = ch_cfg_ff[c][RETRY_BIT] && latched && (retry_ff >= RETRY_CYC - 1);
    assign clr = fault_clear | retry_done;

    always_ff @(posedge i_clk) begin
      if (i_reset || !out_ff[c]) begin
        on_cnt_ff <= 32'h0;
      end else if (inrush[c]) begin
        on_cnt_ff <= on_cnt_ff + 32'h1;
      end
    end

    always_ff @(posedge i_clk) begin
      if (i_reset || !latched || !ch_cfg_ff[c][RETRY_BIT] || retry_done) begin
        retry_ff <= 32'h0;
      end else begin
        retry_ff <= retry_ff + 32'h1;
      end
    end

    // A new event in the clearing cycle keeps its flag set
    always_ff @(posedge i_clk) begin
      if (cfg_rst) begin
        oc_ff[c] <= 1'b0;
        sc_ff[c] <= 1'b0;
        ot_ff[c] <= 1'b0;
        olf_ff[c] <= 1'b0;
        oln_ff[c] <= 1'b0;
      end else begin
        oc_ff[c] <= trip_oc | (oc_ff[c] & ~clr);
        sc_ff[c] <= (out_ff[c] & sync2_ff[IX_SC + c]) | (sc_ff[c] & ~clr);
        ot_ff[c] <= sync2_ff[IX_OT + c] | (ot_ff[c] & ~clr);
        olf_ff[c] <= (~out_ff[c] & sync2_ff[IX_OLOFF + c]) | (olf_ff[c] & ~fault_clear);
        oln_ff[c] <= (out_ff[c] & sync2_ff[IX_OLON + c]) | (oln_ff[c] & ~fault_clear);
      end
    end

    always_ff @(posedge i_clk) begin
      if (i_reset) begin
        out_ff[c] <= 1'b0;
      end else begin
        out_ff[c] <= req & ~latched & ~sleeping;
      end
    end

    always_ff @(posedge i_clk) begin
      if (i_reset) begin
        o_oc_limit_high[c] <= 1'b0;
      end else begin
        o_oc_limit_high[c] <= inrush[c];
      end
    end
  end

  assign o_switch_out_0 = out_ff[0];
  assign o_switch_out_1 = out_ff[1];

  // ==========================================================
  // Sense selection and accuracy window
  sense_e sense_sel;
  logic sense_on;
  logic [15:0] settle_ff;
  sense_e sel_prev_ff;
  logic sense_ok;

  assign sense_sel = sense_e'(glb_cfg_ff[SENSE_SEL_LSB +: 2]);
  assign sense_on = (sense_sel == SENSE_CUR0) ? out_ff[0] :
                    (sense_sel == SENSE_CUR1) ? out_ff[1] : 1'b1;
  assign sense_ok = (settle_ff >= 16'(SETTLE_CYC));

  // A channel current reading needs the switch on and settled
  always_ff @(posedge i_clk) begin
    if (i_reset || !sense_on || sense_sel != sel_prev_ff) begin
      settle_ff <= 16'h0000;
    end else if (!sense_ok) begin
      settle_ff <= settle_ff + 16'h0001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      sel_prev_ff <= SENSE_CUR0;
      o_sense_select <= 2'h0;
      o_sense_ratio <= 1'b0;
      o_sync_n <= 1'b1;
      o_sync_oe <= 1'b0;
    end else begin
      sel_prev_ff <= sense_sel;
      o_sense_select <= glb_cfg_ff[SENSE_SEL_LSB +: 2];
      o_sense_ratio <= glb_cfg_ff[RATIO_BIT];
      o_sync_n <= ~sense_ok;
      o_sync_oe <= sense_ok;
    end
  end

  // ==========================================================
  // Mode and fault pins, reply word
  logic fault_any;

  assign fault_any = |{oc_ff, sc_ff, ot_ff, olf_ff, oln_ff};

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_failsafe_out_n <= 1'b1;
      o_failsafe_out_oe <= 1'b0;
      o_fault_flag_n <= 1'b1;
      o_fault_flag_oe <= 1'b0;
      o_sleep <= 1'b0;
    end else begin
      o_failsafe_out_n <= ~failsafe;
      o_failsafe_out_oe <= failsafe;
      o_fault_flag_n <= ~fault_any;
      o_fault_flag_oe <= fault_any;
      o_sleep <= sleeping;
    end
  end

  // The reply only changes between frames so the link sees a steady word
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      tx_word_ff <= 16'h0000;
    end else if (cs_idle) begin
      tx_word_ff <= {failsafe, fault_any, oln_ff, olf_ff, ot_ff, sc_ff, oc_ff, out_ff, sleeping, 1'b0};
    end
  end

endmodule  // dual_switch_control_pins

// >>> tb/dsw_monitor.sv
module dsw_monitor import dsw_pkg::*; #(
  parameter int unsigned WDOG_CYC = WDOG_CYC_DEF
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_chip_select_n,
  input wire logic i_reset_n,
  input wire logic i_direct_input_0,
  input wire logic i_direct_input_1,
  input wire logic [1:0] i_short,
  input wire logic o_switch_out_0,
  input wire logic o_switch_out_1,
  input wire logic o_failsafe_out_n,
  input wire logic o_failsafe_out_oe,
  input wire logic o_fault_flag_n,
  input wire logic o_fault_flag_oe,
  input wire logic o_sync_n,
  input wire logic o_sync_oe,
  input wire logic o_sleep
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  // ==========================================================
  // Host silence counter; any select activity restarts it, so it never overstates the idle time
  logic [31:0] idle_ff;
  always_ff @(posedge i_clk) begin
    if (i_reset || !i_chip_select_n || o_sleep || !i_reset_n) begin
      idle_ff <= 32'h0;
    end else if (idle_ff != 32'hffffffff) begin
      idle_ff <= idle_ff + 32'h1;
    end
  end

  // A short only latches while the channel is on, so the window opens with it on
  sequence s_short_held;
    (o_switch_out_0 && i_short[0] && i_reset_n) ##1 (i_short[0] && i_reset_n) [*5];
  endsequence
  sequence s_sleep_req;
    (!i_reset_n && !i_direct_input_0 && !i_direct_input_1) [*5];
  endsequence

  // ==========================================================
  // Properties
  a_failsafe_pin_low: assert property (o_failsafe_out_oe |-> !o_failsafe_out_n)
    else $error("failsafe pin enabled but not low");
  a_fault_pin_low: assert property (o_fault_flag_oe |-> !o_fault_flag_n)
    else $error("fault pin enabled but not low");
  a_sync_pin_low: assert property (o_sync_oe |-> !o_sync_n)
    else $error("sync pin enabled but not low");
  a_short_forces_off: assert property (s_short_held |-> !o_switch_out_0 && !o_fault_flag_n)
    else $error("short did not turn channel off");
  a_sleep_entry: assert property (s_sleep_req |-> o_sleep)
    else $error("no sleep while reset pin low");
  a_sleep_blocked: assert property ((i_direct_input_0 || i_direct_input_1) [*5] |-> !o_sleep)
    else $error("sleep while a direct input is on");
  a_failsafe_timeout: assert property (idle_ff == WDOG_CYC + 8 |-> !o_failsafe_out_n)
    else $error("host silence did not give failsafe");
  a_failsafe_direct: assert property ((!o_failsafe_out_n && !i_direct_input_1) [*5] |-> !o_switch_out_1)
    else $error("failsafe channel not under direct input");
  a_reset_quiet: assert property (disable iff (1'b0)
    i_reset |=> !o_switch_out_0 && !o_failsafe_out_oe && !o_fault_flag_oe && !o_sleep)
    else $error("outputs active after reset");
endmodule // dsw_monitor

bind dual_switch_control_pins dsw_monitor #(.WDOG_CYC(WDOG_CYC)) u_monitor (
  .i_clk(i_clk), .i_reset(i_reset), .i_chip_select_n(i_chip_select_n), .i_reset_n(i_reset_n),
  .i_direct_input_0(i_direct_input_0), .i_direct_input_1(i_direct_input_1), .i_short(i_short),
  .o_switch_out_0(o_switch_out_0), .o_switch_out_1(o_switch_out_1), .o_failsafe_out_n(o_failsafe_out_n),
  .o_failsafe_out_oe(o_failsafe_out_oe), .o_fault_flag_n(o_fault_flag_n), .o_fault_flag_oe(o_fault_flag_oe),
  .o_sync_n(o_sync_n), .o_sync_oe(o_sync_oe), .o_sleep(o_sleep)
);

// >>> tb/host_model.sv
module host_model (
  output logic o_sclk,
  output logic o_chip_select_n,
  output logic o_si,
  input wire logic i_so
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_sclk = 1'b0;
    o_chip_select_n = 1'b1;
    o_si = 1'b0;
  end

  // ==========================================================
  // One frame; clock idles low and data falls to its pull-down level outside frames
  task automatic xfer(input logic [15:0] cmd, input int nbits, output logic [15:0] rsp);
    rsp = 16'h0000;
    o_chip_select_n = 1'b0;
    #30;
    for (int k = 15; k > 15 - nbits; k--) begin
      o_sclk = 1'b1;
      o_si = cmd[k];
      #7.5;
      o_sclk = 1'b0;
      rsp[k] = i_so;
      #7.5;
    end
    #7.5;
    o_chip_select_n = 1'b1;
    o_si = 1'b0;
    #60;
  endtask
endmodule // host_model

// >>> tb/testbench.sv
module testbench import dsw_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned T_WDOG = 20000;
  localparam int unsigned T_BULB = 20;
  localparam int unsigned T_MOTOR = 50;
  localparam int unsigned T_RETRY = 30;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic sclk, cs_n, si, so;
  logic rst_n = 1'b1, din0 = 1'b0, din1 = 1'b0, prof0 = 1'b0, prof1 = 1'b0, pwm_clk = 1'b0;
  logic [1:0] short_in = 2'h0, ot_in = 2'h0, olo_in = 2'h0, oc_lo_in = 2'h0, oln_in = 2'h0;
  logic out0, out1, fs_n, fs_oe, flt_n, flt_oe, sync_n, sync_oe, slp, sratio;
  logic [1:0] ssel, oc_hi;
  logic [15:0] rsp;
  int n_fail = 0;
  int total_checks = 0;
  always #5 i_clk = ~i_clk;

  dual_switch_control_pins #(.WDOG_CYC(T_WDOG), .BULB_CYC(T_BULB), .MOTOR_CYC(T_MOTOR), .RETRY_CYC(T_RETRY)) uut (
    .i_clk(i_clk), .i_reset(i_reset), .i_sclk(sclk), .i_chip_select_n(cs_n), .i_si(si), .i_reset_n(rst_n),
    .i_direct_input_0(din0), .i_direct_input_1(din1), .i_profile_select_0(prof0), .i_profile_select_1(prof1),
    .i_pwm_clock(pwm_clk), .i_overcurrent_high(2'h0), .i_overcurrent_low(oc_lo_in), .i_short(short_in),
    .i_overtemp(ot_in), .i_openload_off(olo_in), .i_openload_on(oln_in), .o_so(so), .o_switch_out_0(out0),
    .o_switch_out_1(out1), .o_failsafe_out_n(fs_n), .o_failsafe_out_oe(fs_oe), .o_fault_flag_n(flt_n),
    .o_fault_flag_oe(flt_oe), .o_sync_n(sync_n), .o_sync_oe(sync_oe), .o_sense_select(ssel),
    .o_sense_ratio(sratio), .o_oc_limit_high(oc_hi), .o_sleep(slp)
  );
  host_model host (.o_sclk(sclk), .o_chip_select_n(cs_n), .o_si(si), .i_so(so));

  // ==========================================================
  // Shared tasks
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // Settling allows for the select synchroniser plus register and output stages
  task automatic frame(input logic [15:0] cmd);
    host.xfer(cmd, 16, rsp);
    cyc(6);
  endtask
  task automatic stop_test;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge i_clk);
    n_fail++;
    stop_test();
  end

  // ==========================================================
  // Test sequence
  initial begin
    int n;
    cyc(3);
    @(posedge i_clk) i_reset <= 1'b0;
    cyc(1);
    check("reset out", {out1, out0, fs_n, flt_n, slp}, 5'h06);
    @(posedge i_clk) din0 <= 1'b1;
    cyc(6);
    check("direct", {out1, out0}, 2'h1);
    cyc(SETTLE_CYC + 10);
    check("sync", {sync_oe, sync_n}, 2'h2);
    $display("test direct done");
    for (int p = 0; p < 3; p++) begin
      @(posedge i_clk) begin
        din0 <= 1'b0;
        prof0 <= p[0];
        prof1 <= p[0];
      end
      cyc(10);
      // The serial override picks motor although the pins say bulb
      if (p == 2) frame({3'h1, 13'h1800});
      n = 0;
      @(posedge i_clk) din0 <= 1'b1;
      for (int k = 0; k < 200 && !(out0 === 1'b1 && oc_hi[0] === 1'b0); k++) begin
        cyc(1);
        if (out0 === 1'b1 && oc_hi[0] === 1'b1) n++;
      end
      n = n - (p ? T_MOTOR : T_BULB);
      check("inrush", 16'(n >= -1 && n <= 1), 16'h1);
    end
    $display("test profile done");
    for (int s = 0; s < 3; s++) begin
      frame({3'h3, 10'h000, s[0], s[1:0]});
      check("sense", {sratio, ssel}, {s[0], s[1:0]});
    end
    host.xfer({3'h3, 13'h0001}, 15, rsp);
    cyc(6);
    check("short frame", {sratio, ssel}, 3'h2);
    $display("test serial done");
    for (int f = 0; f < 3; f++) begin
      // The steady threshold only applies once the inrush window has passed
      if (f == 2) cyc(T_MOTOR + 10);
      @(posedge i_clk) begin
        short_in <= {1'b0, f == 0};
        ot_in <= {1'b0, f == 1};
        oc_lo_in <= {1'b0, f == 2};
        oln_in <= {1'b0, f == 2};
        olo_in <= 2'h2;
      end
      cyc(8);
      @(posedge i_clk) begin
        short_in <= 2'h0;
        ot_in <= 2'h0;
        oc_lo_in <= 2'h0;
        oln_in <= 2'h0;
        olo_in <= 2'h0;
      end
      cyc(4);
      check("fault off", {out0, flt_oe, flt_n}, 3'h2);
      frame(16'h0000);
      check("reply", rsp, 16'h4800 | (f == 0 ? 16'h0040 : f == 1 ? 16'h0100 : 16'h1010));
      frame({3'h3, 13'h0008});
      check("cleared", {out0, flt_oe, flt_n}, 3'h5);
    end
    frame({3'h1, 13'h0400});
    @(posedge i_clk) short_in <= 2'h1;
    cyc(8);
    @(posedge i_clk) short_in <= 2'h0;
    cyc(4);
    check("tripped", out0, 1'b0);
    cyc(T_RETRY + 10);
    check("retried", out0, 1'b1);
    $display("test protect done");
    // Counting over one whole counter period, after the pin clock has settled, is phase independent
    for (int m = 1; m < 3; m++) begin
      frame({3'h2, 3'h0, m[1:0], 8'h80});
      n = 0;
      for (int k = 0; k < (m == 1 ? 4096 : 1024) + 8; k++) begin
        @(posedge i_clk) pwm_clk <= k[1];
        #1;
        if (k >= 8 && out1 === 1'b1) n++;
      end
      check("pwm", 16'(n), m == 1 ? 16'd2048 : 16'd512);
    end
    $display("test pwm done");
    cyc(T_WDOG + 20);
    check("failsafe", {fs_oe, fs_n}, 2'h2);
    for (int d = 0; d < 2; d++) begin
      @(posedge i_clk) din1 <= d[0];
      cyc(6);
      check("fs direct", out1, d[0]);
    end
    frame(16'h0000);
    check("fs leave", fs_n, 1'b1);
    $display("test failsafe done");
    frame({3'h1, 3'h0, 2'h1, 8'hff});
    @(posedge i_clk) begin
      din0 <= 1'b0;
      din1 <= 1'b0;
      rst_n <= 1'b0;
    end
    cyc(6);
    check("sleep", slp, 1'b1);
    @(posedge i_clk) din0 <= 1'b1;
    cyc(6);
    check("awake", slp, 1'b0);
    @(posedge i_clk) begin
      din0 <= 1'b0;
      rst_n <= 1'b1;
    end
    cyc(6);
    check("cfg reset", {out1, out0, flt_n}, 3'h1);
    $display("test reset pin done");
    stop_test();
  end
endmodule // testbench
